// *** inc/hdm_cfg.svh ***
// Offsets, field positions, reset values and limits of the hybrid deviation monitor.
// Assumes a 32-bit register port with byte offsets on word boundaries.
`ifndef HDM_CFG_SVH
`define HDM_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define HDM_OFS_CTRL        8'h00
`define HDM_OFS_NUM         8'h04
`define HDM_OFS_DEN         8'h08
`define HDM_OFS_LIMIT       8'h0C
`define HDM_OFS_CLR_REVS    8'h10
`define HDM_OFS_STATUS      8'h14
`define HDM_OFS_MASK        8'h18
`define HDM_OFS_DEV_LO      8'h1C
`define HDM_OFS_DEV_HI      8'h20
`define HDM_OFS_POS         8'h24
`define HDM_OFS_REVS        8'h28

// ****************************************************************
// Field positions
// ****************************************************************
`define HDM_CTRL_FULL_CLOSED   0
`define HDM_CTRL_USAGE_LO      1
`define HDM_CTRL_USAGE_HI      2
`define HDM_CTRL_SCALE_REV     3
`define HDM_EV_DEV_ERR         0
`define HDM_EV_AUTO_CLR        1
`define HDM_EV_MT_OVF          2

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define HDM_RST_NUM         21'h000000
`define HDM_RST_DEN         21'h000001
`define HDM_RST_LIMIT       28'h0002710
`define HDM_RST_CLR_REVS    7'h00
`define HDM_RST_USAGE       2'h1
`define HDM_MAX_RATIO       21'h100000
`define HDM_MAX_LIMIT       28'h8000000
`define HDM_MAX_CLR_REVS    7'h64
`define HDM_ENC_RES_DEF     1048576

`endif

// *** inc/hdm_pkg.sv ***
// Types shared by the hybrid deviation monitor files.
// Assumes nothing beyond a SystemVerilog compiler.
package hdm_pkg;

    // Encoder usage modes, in their programmed order 0, 1, 2
    typedef enum logic [1:0] {
        USE_ABSOLUTE,
        USE_INCREMENTAL,
        USE_ABS_NO_OVF
    } abs_usage_t;

endpackage

// *** rtl/pin_sync.sv ***
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous level input and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
    input  wire logic clk_sys,   // System clock
    input  wire logic rst,       // Synchronous reset
    input  wire logic pin_in,    // Raw pin level
    output logic      level      // Filtered level
);

    logic s1;   // First stage, read only by s2
    logic s2;   // Second stage
    logic s3;   // Third stage

    // Shift chain; the first stage feeds the second and nothing else
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end else begin
            s1 <= pin_in;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // Level moves only once two stages agree, rejecting one-cycle glitches
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            level <= 1'b0;
        end else if (s2 == s3) begin
            level <= s3;
        end
    end

endmodule

`default_nettype wire

// *** rtl/hybrid_deviation_monitor.sv ***
// Hybrid deviation monitor: compares ratio-scaled encoder travel with scale travel.
// Assumes step/direction pins from encoder and scale, absolute data on clk_sys,
// and a simple register port driven by a master on the same clock.
`timescale 1ns/10ps
`default_nettype none
`include "hdm_cfg.svh"

// How it works
// - Zero numerator means use encoder resolution
// - Denominator and numerator limited to two-pow-twenty
// - Gap above threshold raises protection error
// - Threshold in command units, one to two-pow-27
// - Clear gap after set revolutions, 0..100
// - Setting zero disables automatic gap clearing
// - Revolutions counted from encoder pulses only
// - Usage selects absolute, incremental, absolute-no-overflow
// - Full-closed control forces incremental usage
// - Absolute mode reports absolute data as position
// - Reverse setting inverts scale count direction
module hybrid_deviation_monitor #(
    parameter int unsigned ENC_RES = `HDM_ENC_RES_DEF  // Encoder pulses per revolution
) (
    input  wire logic        clk_sys,      // System clock, 25 MHz
    input  wire logic        rst,          // Synchronous reset
    input  wire logic [7:0]  reg_addr,     // Register byte offset
    input  wire logic [31:0] reg_wdata,    // Write data
    input  wire logic        reg_wr,       // Write strobe
    input  wire logic        reg_rd,       // Read strobe
    output logic      [31:0] reg_rdata,    // Read data, cycle after strobe
    input  wire logic        enc_step,     // Encoder count pin
    input  wire logic        enc_dir,      // Encoder direction pin, high = up
    input  wire logic        scale_step,   // Scale count pin
    input  wire logic        scale_dir,    // Scale direction pin, high = up
    input  wire logic [31:0] abs_pos,      // Absolute position data
    input  wire logic        abs_mt_ovf,   // Multi-turn overflow pulse
    output logic      [31:0] cur_pos,      // Position for network response
    output logic             prot_err,     // Hybrid deviation protection error
    output logic             irq           // Level interrupt
);

    // ****************************************************************
    // Parameters and widths
    // ****************************************************************
    localparam int ACC_W = 51;   // Room for num steps times limit times den

    if (ENC_RES < 1 || ENC_RES > 1048576) begin : g_bad_res
        $error("ENC_RES out of range");
    end

    localparam logic [20:0] ENC_RES_W = 21'(ENC_RES);   // Resolution at ratio width

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [3:0] pins_raw;    // Raw pin levels
    logic [3:0] pins;        // Filtered pin levels
    logic [3:0] pins_d;      // Filtered levels, one cycle late

    assign pins_raw = {scale_dir, scale_step, enc_dir, enc_step};

    for (genvar i = 0; i < 4; i++) begin : g_sync
        pin_sync u_sync (
            .clk_sys (clk_sys),
            .rst     (rst),
            .pin_in  (pins_raw[i]),
            .level   (pins[i])
        );
    end

    // Edge history of the filtered levels
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pins_d <= 4'h0;
        end else begin
            pins_d <= pins;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic        full_closed;   // Full-closed control active
    logic [1:0]  usage_set;     // Programmed encoder usage
    logic        scale_count_reverse;       // Scale direction reversal
    logic [20:0] scale_ratio_numerator;     // Ratio numerator, 0 = resolution
    logic [20:0] scale_ratio_denominator;   // Ratio denominator
    logic [27:0] deviation_limit;           // Threshold in command units
    logic [6:0]  deviation_clear_revs;      // Revolutions per automatic clear
    logic [2:0]  status;        // Sticky event bits
    logic [2:0]  mask;          // Interrupt enables
    logic        wr_hit;        // Write decoded

    assign wr_hit = reg_wr;

    // Control and ratio writes; out-of-range values leave the old setting
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            full_closed <= 1'b0;
            usage_set <= `HDM_RST_USAGE;
            scale_count_reverse <= 1'b0;
            scale_ratio_numerator <= `HDM_RST_NUM;
            scale_ratio_denominator <= `HDM_RST_DEN;
            deviation_limit <= `HDM_RST_LIMIT;
            deviation_clear_revs <= `HDM_RST_CLR_REVS;
            mask <= 3'h0;
        end else if (wr_hit) begin
            if (reg_addr == `HDM_OFS_CTRL) begin
                if (reg_wdata[`HDM_CTRL_USAGE_HI:`HDM_CTRL_USAGE_LO] != 2'h3) begin
                    full_closed <= reg_wdata[`HDM_CTRL_FULL_CLOSED];
                    usage_set <= reg_wdata[`HDM_CTRL_USAGE_HI:`HDM_CTRL_USAGE_LO];
                    scale_count_reverse <= reg_wdata[`HDM_CTRL_SCALE_REV];
                end
            end else if (reg_addr == `HDM_OFS_NUM) begin
                if (reg_wdata <= 32'(`HDM_MAX_RATIO)) begin
                    scale_ratio_numerator <= reg_wdata[20:0];
                end
            end else if (reg_addr == `HDM_OFS_DEN) begin
                if (reg_wdata != 32'h0000_0000 && reg_wdata <= 32'(`HDM_MAX_RATIO)) begin
                    scale_ratio_denominator <= reg_wdata[20:0];
                end
            end else if (reg_addr == `HDM_OFS_LIMIT) begin
                if (reg_wdata != 32'h0000_0000 && reg_wdata <= 32'(`HDM_MAX_LIMIT)) begin
                    deviation_limit <= reg_wdata[27:0];
                end
            end else if (reg_addr == `HDM_OFS_CLR_REVS) begin
                if (reg_wdata <= 32'(`HDM_MAX_CLR_REVS)) begin
                    deviation_clear_revs <= reg_wdata[6:0];
                end
            end else if (reg_addr == `HDM_OFS_MASK) begin
                mask <= reg_wdata[2:0];
            end
        end
    end

    // ****************************************************************
    // Effective settings
    // ****************************************************************
    hdm_pkg::abs_usage_t usage_eff;   // Usage as the logic applies it
    logic [20:0] num_eff;             // Numerator as the logic applies it

    assign usage_eff = full_closed ? hdm_pkg::USE_INCREMENTAL
                                   : hdm_pkg::abs_usage_t'(usage_set);
    assign num_eff = (scale_ratio_numerator == 21'h000000) ? ENC_RES_W
                                                           : scale_ratio_numerator;

    // ****************************************************************
    // Step decoding
    // ****************************************************************
    logic enc_mv;    // Encoder pulse this cycle
    logic enc_up;    // Encoder pulse counting up
    logic scl_mv;    // Scale pulse this cycle
    logic scl_up;    // Scale pulse counting up after reversal

    assign enc_mv = pins[0] && !pins_d[0];
    assign enc_up = enc_mv && pins[1];
    assign scl_mv = pins[2] && !pins_d[2];
    assign scl_up = scl_mv && (pins[3] ^ scale_count_reverse);

    // ****************************************************************
    // Revolution counter
    // ****************************************************************
    logic [20:0] rev_pulses;   // Encoder pulses within the current revolution
    logic [6:0]  revs;         // Completed revolutions since last clear
    logic        rev_done;     // This pulse completes a revolution
    logic        auto_clr;     // Automatic deviation clear this cycle

    assign rev_done = enc_mv && (rev_pulses == ENC_RES_W - 21'h000001);
    assign auto_clr = rev_done && (deviation_clear_revs != 7'h00)
                      && (revs + 7'h01 == deviation_clear_revs);

    // counted from encoder pulses only
    // Either direction counts, so back-and-forth travel also ages the gap out
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rev_pulses <= 21'h000000;
            revs <= 7'h00;
        end else if (enc_mv) begin
            if (rev_done) begin
                rev_pulses <= 21'h000000;
                revs <= auto_clr ? 7'h00 : ((revs == 7'h7F) ? revs : revs + 7'h01);
            end else begin
                rev_pulses <= rev_pulses + 21'h000001;
            end
        end
    end

    // ****************************************************************
    // Deviation accumulator
    // ****************************************************************
    // Kept in units of one scale pulse over the denominator, so no division
    // is needed and the ratio stays exact over any travel length.
    logic signed [ACC_W-1:0] acc;        // Motor minus scale, times denominator
    logic signed [ACC_W-1:0] next_acc;   // Accumulator next value
    logic signed [ACC_W-1:0] num_x;      // Numerator at accumulator width
    logic signed [ACC_W-1:0] den_x;      // Denominator at accumulator width
    logic        [ACC_W-1:0] acc_mag;    // Magnitude of the accumulator
    logic        [48:0]      thresh;     // Limit times denominator

    assign num_x = {{(ACC_W-21){1'b0}}, num_eff};
    assign den_x = {{(ACC_W-21){1'b0}}, scale_ratio_denominator};
    assign thresh = deviation_limit * scale_ratio_denominator;
    assign acc_mag = acc[ACC_W-1] ? -acc : acc;

    always_comb begin
        next_acc = acc;
        if (enc_mv) begin
            next_acc = enc_up ? next_acc + num_x : next_acc - num_x;
        end
        if (scl_mv) begin
            next_acc = scl_up ? next_acc - den_x : next_acc + den_x;
        end
        if (auto_clr) begin
            next_acc = '0;
        end
    end

    // Accumulator register; a clear in the same cycle drops that cycle's pulses
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            acc <= '0;
        end else begin
            acc <= next_acc;
        end
    end

    // ****************************************************************
    // Events, status and interrupt
    // ****************************************************************
    logic [2:0] events;   // Events raised this cycle
    logic [2:0] w1c;      // Bits cleared by software this cycle
    logic       dev_over; // Gap beyond threshold

    assign dev_over = acc_mag > {{(ACC_W-49){1'b0}}, thresh};

    always_comb begin
        events = 3'h0;
        events[`HDM_EV_DEV_ERR] = dev_over;
        events[`HDM_EV_AUTO_CLR] = auto_clr;
        events[`HDM_EV_MT_OVF] = abs_mt_ovf && (usage_eff == hdm_pkg::USE_ABSOLUTE);
    end

    assign w1c = (wr_hit && reg_addr == `HDM_OFS_STATUS) ? reg_wdata[2:0] : 3'h0;

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status <= 3'h0;
        end else begin
            status <= (status & ~w1c) | events;
        end
    end

    assign prot_err = status[`HDM_EV_DEV_ERR];
    assign irq = |(status & mask);

    // ****************************************************************
    // Position report
    // ****************************************************************
    logic [31:0] inc_pos;   // Incremental encoder position

    // Incremental count from power-up, no homing offset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            inc_pos <= 32'h0000_0000;
        end else if (enc_mv) begin
            inc_pos <= enc_up ? inc_pos + 32'h0000_0001 : inc_pos - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cur_pos <= 32'h0000_0000;
        end else if (usage_eff == hdm_pkg::USE_INCREMENTAL) begin
            cur_pos <= inc_pos;
        end else begin
            cur_pos <= abs_pos;
        end
    end

    // ****************************************************************
    // Register read port
    // ****************************************************************
    // Read data stand one cycle, zero otherwise; unmapped offsets read zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_addr == `HDM_OFS_CTRL) begin
            reg_rdata <= {28'h0000000, scale_count_reverse, usage_set, full_closed};
        end else if (reg_addr == `HDM_OFS_NUM) begin
            reg_rdata <= {11'h000, scale_ratio_numerator};
        end else if (reg_addr == `HDM_OFS_DEN) begin
            reg_rdata <= {11'h000, scale_ratio_denominator};
        end else if (reg_addr == `HDM_OFS_LIMIT) begin
            reg_rdata <= {4'h0, deviation_limit};
        end else if (reg_addr == `HDM_OFS_CLR_REVS) begin
            reg_rdata <= {25'h0000000, deviation_clear_revs};
        end else if (reg_addr == `HDM_OFS_STATUS) begin
            reg_rdata <= {29'h00000000, status};
        end else if (reg_addr == `HDM_OFS_MASK) begin
            reg_rdata <= {29'h00000000, mask};
        end else if (reg_addr == `HDM_OFS_DEV_LO) begin
            reg_rdata <= acc[31:0];
        end else if (reg_addr == `HDM_OFS_DEV_HI) begin
            reg_rdata <= {{13{acc[ACC_W-1]}}, acc[ACC_W-1:32]};
        end else if (reg_addr == `HDM_OFS_POS) begin
            reg_rdata <= cur_pos;
        end else if (reg_addr == `HDM_OFS_REVS) begin
            reg_rdata <= {25'h0000000, revs};
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence seq_enc_only;
        enc_up && !scl_mv && !auto_clr;
    endsequence

    // Built from the filtered pin, not scl_up, so a lost reversal still trips it
    sequence seq_scl_up_only;
        scl_mv && (pins[3] != scale_count_reverse) && !enc_mv && !auto_clr;
    endsequence

    sequence seq_last_rev;
        rev_done && deviation_clear_revs != 7'h00 && revs + 7'h01 == deviation_clear_revs;
    endsequence

    chk_num_select: assert property (@(posedge clk_sys) disable iff (rst)
        (seq_enc_only and (scale_ratio_numerator == 21'h000000))
        |=> acc == $past(acc) + {{(ACC_W-21){1'b0}}, ENC_RES_W})
        else $error("zero numerator did not use resolution");

    chk_den_range: assert property (@(posedge clk_sys) disable iff (rst)
        scale_ratio_denominator != 21'h000000 && scale_ratio_denominator <= `HDM_MAX_RATIO)
        else $error("denominator out of range");

    chk_dev_trip: assert property (@(posedge clk_sys) disable iff (rst)
        dev_over |=> prot_err)
        else $error("protection error not raised");

    chk_limit_range: assert property (@(posedge clk_sys) disable iff (rst)
        deviation_limit != 28'h0000000 && deviation_limit <= `HDM_MAX_LIMIT)
        else $error("threshold out of range");

    chk_auto_clear: assert property (@(posedge clk_sys) disable iff (rst)
        seq_last_rev |=> acc == '0 && revs == 7'h00)
        else $error("deviation not cleared after revolutions");

    chk_no_clear_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (deviation_clear_revs == 7'h00 && rev_done && enc_up && !scl_mv)
        |=> acc == $past(acc) + $past(num_x))
        else $error("clear with zero setting");

    chk_rev_source: assert property (@(posedge clk_sys) disable iff (rst)
        (scl_mv && !enc_mv) |=> $stable(rev_pulses) && $stable(revs))
        else $error("scale pulse moved revolution count");

    chk_ovf_ignore: assert property (@(posedge clk_sys) disable iff (rst)
        (abs_mt_ovf && usage_eff == hdm_pkg::USE_ABS_NO_OVF && !status[2]
         && !(wr_hit && reg_addr == `HDM_OFS_STATUS)) |=> !status[2])
        else $error("overflow flagged in ignore mode");

    chk_full_closed_inc: assert property (@(posedge clk_sys) disable iff (rst)
        full_closed |=> cur_pos == $past(inc_pos))
        else $error("full-closed did not report incremental");

    chk_abs_report: assert property (@(posedge clk_sys) disable iff (rst)
        usage_eff != hdm_pkg::USE_INCREMENTAL |=> cur_pos == $past(abs_pos))
        else $error("absolute data not reported");

    chk_scale_reverse: assert property (@(posedge clk_sys) disable iff (rst)
        seq_scl_up_only |=> acc == $past(acc) - {{(ACC_W-21){1'b0}}, $past(scale_ratio_denominator)})
        else $error("scale direction wrong");

    chk_enc_accum: assert property (@(posedge clk_sys) disable iff (rst)
        seq_enc_only |=> acc == $past(acc) + {{(ACC_W-21){1'b0}}, $past(num_eff)})
        else $error("encoder step not accumulated");

    chk_reset_clear: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(rst) |-> acc == '0 && revs == 7'h00 && rev_pulses == 21'h000000)
        else $error("state not cleared by reset");

endmodule

`default_nettype wire

// *** test/pulse_src.sv ***
// Partner model: encoder and scale count/direction pins.
// Assumes clk_sys from the bench; the step pins idle low between pulses, the direction pins keep their last level.
`timescale 1ns/10ps
`default_nettype none

module pulse_src (
    input  wire logic clk_sys,     // System clock
    output logic      enc_step,    // Encoder count pin
    output logic      enc_dir,     // Encoder direction, high = up
    output logic      scale_step,  // Scale count pin
    output logic      scale_dir    // Scale direction, high = up
);
    // Idle levels from time zero
    initial begin
        enc_step   = 1'b0;
        enc_dir    = 1'b0;
        scale_step = 1'b0;
        scale_dir  = 1'b0;
    end

    // One pulse; each level held 4 cycles so the 3-stage filter sees it
    task automatic pulse(input logic scl, input logic up);
        @(posedge clk_sys);
        if (scl) scale_dir <= up; else enc_dir <= up;
        repeat (4) @(posedge clk_sys);
        if (scl) scale_step <= 1'b1; else enc_step <= 1'b1;
        repeat (4) @(posedge clk_sys);
        scale_step <= 1'b0;
        enc_step   <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
endmodule

`default_nettype wire

// *** test/hybrid_deviation_monitor_tb_top.sv ***
// Self-checking bench for the hybrid deviation monitor.
// Assumes pulse_src drives the pins and offsets follow hdm_cfg.svh.
`timescale 1ns/10ps
`default_nettype none
`include "hdm_cfg.svh"

module hybrid_deviation_monitor_tb_top;
    localparam int unsigned RES = 8;  // Short revolution keeps the run brief
    logic        clk_sys    = 1'b0;   // System clock
    logic        rst        = 1'b1;   // Reset
    logic [7:0]  reg_addr   = 8'h00;  // Register offset
    logic [31:0] reg_wdata  = 32'h0;  // Write data
    logic        reg_wr     = 1'b0;   // Write strobe
    logic        reg_rd     = 1'b0;   // Read strobe
    logic [31:0] abs_pos    = 32'h0;  // Absolute data
    logic        abs_mt_ovf = 1'b0;   // Overflow event
    logic [31:0] reg_rdata, cur_pos, n;
    logic        enc_step, enc_dir, scale_step, scale_dir, prot_err, irq;
    int          num_errors = 0;
    int          num_checks = 0;

    always #20 clk_sys = ~clk_sys;

    hybrid_deviation_monitor #(.ENC_RES(RES)) u_hybrid_deviation_monitor (.clk_sys(clk_sys),
        .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .enc_step(enc_step), .enc_dir(enc_dir),
        .scale_step(scale_step), .scale_dir(scale_dir), .abs_pos(abs_pos),
        .abs_mt_ovf(abs_mt_ovf), .cur_pos(cur_pos), .prot_err(prot_err), .irq(irq));
    pulse_src u_pulse_src (.clk_sys(clk_sys), .enc_step(enc_step), .enc_dir(enc_dir),
        .scale_step(scale_step), .scale_dir(scale_dir));

    // Zero numerator stands for one revolution of pulses
    function automatic logic [31:0] eff_num(input logic [31:0] v);
        return (v == 32'h0) ? RES : v;
    endfunction
    // Incremental count (zero here) unless absolute data applies
    function automatic logic [31:0] exp_pos(input int k, input logic [31:0] a);
        return (k == 1 || k == 3) ? 32'h0 : a;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, got, exp);
        end
    endtask
    // Extra edge after the strobe so two writes never share a step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
        @(posedge clk_sys);
    endtask
    task automatic do_reset;
        rst <= 1'b1;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a failure
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h7034));
        do_reset();
        rc(`HDM_OFS_DEN, 32'h1);
        rc(8'h3C, 32'h0);
        n = ($urandom % 32'hF) + 32'h1;
        u_pulse_src.pulse(1'b0, 1'b1);
        rc(`HDM_OFS_DEV_LO, eff_num(32'h0));
        wr(`HDM_OFS_NUM, n);
        u_pulse_src.pulse(1'b0, 1'b1);
        rc(`HDM_OFS_DEV_LO, RES + eff_num(n));
        wr(`HDM_OFS_NUM, 32'h100001);
        rc(`HDM_OFS_NUM, n);
        wr(`HDM_OFS_DEN, 32'h0);
        rc(`HDM_OFS_DEN, 32'h1);
        $display("ratio test done");
        do_reset();
        // clear count set only after one revolution
        for (int i = 0; i < 16; i++) begin
            u_pulse_src.pulse(1'b0, 1'b1);
            if (i == 6) begin
                u_pulse_src.pulse(1'b1, 1'b1);
                rc(`HDM_OFS_REVS, 32'h0);
            end
            if (i == 7) begin
                rc(`HDM_OFS_DEV_LO, 32'h3F);
                wr(`HDM_OFS_CLR_REVS, 32'h2);
            end
        end
        rc(`HDM_OFS_DEV_LO, 32'h0);
        rc(`HDM_OFS_STATUS, 32'h2);
        $display("revolution test done");
        do_reset();
        wr(`HDM_OFS_MASK, 32'h1);
        u_pulse_src.pulse(1'b1, 1'b1);
        rc(`HDM_OFS_DEV_HI, 32'hFFFFFFFF);
        wr(`HDM_OFS_CTRL, 32'hA);
        u_pulse_src.pulse(1'b1, 1'b1);
        rc(`HDM_OFS_DEV_LO, 32'h0);
        wr(`HDM_OFS_LIMIT, 32'h8);
        u_pulse_src.pulse(1'b0, 1'b1);
        #1 chk({31'h0, prot_err}, 32'h0);
        wr(`HDM_OFS_LIMIT, 32'h8000001);
        rc(`HDM_OFS_LIMIT, 32'h8);
        wr(`HDM_OFS_LIMIT, 32'h7);
        repeat (2) @(posedge clk_sys);
        #1 chk({30'h0, prot_err, irq}, 32'h3);
        wr(`HDM_OFS_MASK, 32'h0);
        #1 chk({31'h0, irq}, 32'h0);
        rc(`HDM_OFS_LIMIT, 32'h7);
        $display("limit test done");
        do_reset();
        for (int k = 0; k < 4; k++) begin
            wr(`HDM_OFS_CTRL, (k == 3) ? 32'h1 : 32'(k * 2));
            abs_pos    <= $urandom;
            abs_mt_ovf <= 1'b1;
            @(posedge clk_sys);
            abs_mt_ovf <= 1'b0;
            repeat (2) @(posedge clk_sys);
            #1 chk(cur_pos, exp_pos(k, abs_pos));
            rc(`HDM_OFS_STATUS, (k == 0) ? 32'h4 : 32'h0);
            wr(`HDM_OFS_STATUS, 32'h7);
        end
        $display("usage test done");
        end_of_test();
    end
endmodule

`default_nettype wire
